//--- hdl/fifo_host.sv
// Purpose: host controller driving one asynchronous fifo through its pins
// Assumes: one fifo or a width row; flags of one device are sampled
// Notes: software issues init, replay, write and read via registers
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module fifo_host #(
  parameter int WIDTH = 9,
  parameter int DEVICES = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_rdata,
  output logic [WIDTH-1:0] o_in_word,
  input wire logic [WIDTH-1:0] i_out_word,
  output logic o_write_n,
  output logic o_fetch_n,
  output logic o_init_n,
  output logic o_replay_n,
  output logic o_first_in_chain_n,
  input wire logic i_empty_flag_n,
  input wire logic i_full_flag_n,
  input wire logic i_half_level_flag_n,
  output logic o_busy
);
  // synchronisers for the flag pins; stage one is read by stage two only
  logic [2:0] flag_meta_reg;
  logic [2:0] flag_sync_reg;
  logic [WIDTH-1:0] word_meta_reg;
  logic [WIDTH-1:0] word_sync_reg;
  logic empty_n;
  logic full_n;
  logic half_n;
  assign empty_n = flag_sync_reg[0];
  assign full_n = flag_sync_reg[1];
  assign half_n = flag_sync_reg[2];

  // in depth or compound chains these pins carry composite flags
  // flags of a single device are enough for a width row
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flag_meta_reg <= 3'h0;
      flag_sync_reg <= 3'h0;
      word_meta_reg <= '0;
      word_sync_reg <= '0;
    end
    else
    begin
      flag_meta_reg <= {i_half_level_flag_n, i_full_flag_n, i_empty_flag_n};
      flag_sync_reg <= flag_meta_reg;
      word_meta_reg <= i_out_word;
      word_sync_reg <= word_meta_reg;
    end
  end

  // sequencer state
  fifo_host_pkg::phase_type phase_reg, phase_next;
  fifo_host_pkg::op_type op_reg, op_next;
  logic [3:0] count_reg, count_next;
  logic [WIDTH-1:0] wdata_reg, wdata_next;
  logic [WIDTH-1:0] rdata_reg, rdata_next;
  logic first_reg, first_next;
  logic depth_reg, depth_next;
  logic refused_reg, refused_next;
  logic [15:0] wcount_reg, wcount_next;
  logic [15:0] rcount_reg, rcount_next;
  logic write_n_reg, write_n_next;
  logic fetch_n_reg, fetch_n_next;
  logic init_n_reg, init_n_next;
  logic replay_n_reg, replay_n_next;

  // cycle counter helper: steps a count down, holding at zero
  function automatic logic [3:0] step_down(input logic [3:0] value);
    step_down = (value == 4'h0) ? 4'h0 : value - 4'h1;
  endfunction : step_down

  always_comb
  begin
    phase_next = phase_reg;
    op_next = op_reg;
    count_next = step_down(count_reg);
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    first_next = first_reg;
    depth_next = depth_reg;
    refused_next = refused_reg;
    wcount_next = wcount_reg;
    rcount_next = rcount_reg;
    write_n_next = write_n_reg;
    fetch_n_next = fetch_n_reg;
    init_n_next = init_n_reg;
    replay_n_next = replay_n_reg;
    if (i_write && i_addr == fifo_host_pkg::OFS_WDATA)
      wdata_next = i_wdata[WIDTH-1:0];
    unique case (phase_reg)
      fifo_host_pkg::ST_IDLE:
      begin
        // one command at a time; commands arriving while busy are dropped
        if (i_write && i_addr == fifo_host_pkg::OFS_CTRL)
        begin
          refused_next = 1'b0;
          depth_next = i_wdata[fifo_host_pkg::CTRL_DEPTH];
          first_next = i_wdata[fifo_host_pkg::CTRL_FIRST];
          phase_next = fifo_host_pkg::ST_SETUP;
          count_next = fifo_host_pkg::PULSE_CNT;
          if (i_wdata[fifo_host_pkg::CTRL_INIT])
            op_next = fifo_host_pkg::OP_INIT;
          else if (i_wdata[fifo_host_pkg::CTRL_REPLAY])
            op_next = fifo_host_pkg::OP_REPLAY;
          else if (i_wdata[fifo_host_pkg::CTRL_WRITE])
            op_next = fifo_host_pkg::OP_WRITE;
          else if (i_wdata[fifo_host_pkg::CTRL_READ])
            op_next = fifo_host_pkg::OP_READ;
          else
            phase_next = fifo_host_pkg::ST_IDLE;
        end
      end
      fifo_host_pkg::ST_SETUP:
      begin
        // strobes are high here, giving the setup time before a pulse
        if (count_reg == 4'h0)
        begin
          phase_next = fifo_host_pkg::ST_STROBE;
          count_next = fifo_host_pkg::PULSE_CNT;
          unique case (op_reg)
            fifo_host_pkg::OP_INIT:
              init_n_next = 1'b0;
            fifo_host_pkg::OP_REPLAY:
            begin
              // replay is unavailable when chained in depth
              if (depth_reg)
              begin
                refused_next = 1'b1;
                phase_next = fifo_host_pkg::ST_IDLE;
              end
              else
                replay_n_next = 1'b0;
            end
            fifo_host_pkg::OP_WRITE:
            begin
              // falling write edge only while full is deasserted
              if (full_n)
                write_n_next = 1'b0;
              else
              begin
                refused_next = 1'b1;
                phase_next = fifo_host_pkg::ST_IDLE;
              end
            end
            fifo_host_pkg::OP_READ:
            begin
              if (empty_n)
              begin
                fetch_n_next = 1'b0;
                count_next = fifo_host_pkg::ACCESS_CNT +
                  fifo_host_pkg::SYNC_CNT;
              end
              else
              begin
                refused_next = 1'b1;
                phase_next = fifo_host_pkg::ST_IDLE;
              end
            end
          endcase
        end
      end
      fifo_host_pkg::ST_STROBE:
      begin
        if (count_reg == 4'h0)
        begin
          // data is valid only while the read strobe is low
          if (op_reg == fifo_host_pkg::OP_READ)
          begin
            rdata_next = word_sync_reg;
            rcount_next = rcount_reg + 16'h0001;
          end
          if (op_reg == fifo_host_pkg::OP_WRITE)
            wcount_next = wcount_reg + 16'h0001;
          if (op_reg != fifo_host_pkg::OP_WRITE)
            rcount_next = (op_reg == fifo_host_pkg::OP_READ) ?
              rcount_reg + 16'h0001 : 16'h0000;
          if (op_reg == fifo_host_pkg::OP_INIT)
            wcount_next = 16'h0000;
          write_n_next = 1'b1;
          fetch_n_next = 1'b1;
          init_n_next = 1'b1;
          replay_n_next = 1'b1;
          phase_next = fifo_host_pkg::ST_RECOVER;
          count_next = fifo_host_pkg::RECOVER_CNT;
        end
      end
      fifo_host_pkg::ST_RECOVER:
      begin
        // strobes stay high through recovery after init or replay
        if (count_reg == 4'h0)
          phase_next = fifo_host_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers; strobes come up high and init idle
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_reg <= fifo_host_pkg::ST_IDLE;
      op_reg <= fifo_host_pkg::OP_INIT;
      count_reg <= 4'h0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      first_reg <= 1'b0;
      depth_reg <= 1'b0;
      refused_reg <= 1'b0;
      wcount_reg <= 16'h0000;
      rcount_reg <= 16'h0000;
      write_n_reg <= 1'b1;
      fetch_n_reg <= 1'b1;
      init_n_reg <= 1'b1;
      replay_n_reg <= 1'b1;
    end
    else
    begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      count_reg <= count_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      first_reg <= first_next;
      depth_reg <= depth_next;
      refused_reg <= refused_next;
      wcount_reg <= wcount_next;
      rcount_reg <= rcount_next;
      write_n_reg <= write_n_next;
      fetch_n_reg <= fetch_n_next;
      init_n_reg <= init_n_next;
      replay_n_reg <= replay_n_next;
    end
  end

  // pins: first-in-chain low marks the first device
  assign o_in_word = wdata_reg; // one direction; pair for two-way
  assign o_write_n = write_n_reg;
  assign o_fetch_n = fetch_n_reg;
  assign o_init_n = init_n_reg;
  assign o_replay_n = depth_reg ? ~first_reg : replay_n_reg;
  assign o_first_in_chain_n = ~first_reg; // chain wired outside
  assign o_busy = (phase_reg != fifo_host_pkg::ST_IDLE);

  // read port: data one cycle after the strobe; flags active low
  logic [15:0] rdout_reg, rdout_next;
  always_comb
  begin
    rdout_next = 16'h0000;
    if (i_read)
    begin
      unique case (i_addr)
        fifo_host_pkg::OFS_CTRL:
          rdout_next = {10'h000, depth_reg, first_reg, 4'h0};
        fifo_host_pkg::OFS_STATUS:
          rdout_next = {11'h000, refused_reg, o_busy,
                        depth_reg | half_n, full_n, empty_n};
        fifo_host_pkg::OFS_WDATA:
          rdout_next = 16'(wdata_reg);
        fifo_host_pkg::OFS_RDATA:
          rdout_next = 16'(rdata_reg);
        fifo_host_pkg::OFS_WCOUNT:
          rdout_next = wcount_reg;
        fifo_host_pkg::OFS_RCOUNT:
          rdout_next = rcount_reg;
        default:
          rdout_next = 16'h0000;
      endcase
    end
  end

  // read data register; cycles without a read return zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdout_reg <= 16'h0000;
    else
      rdout_reg <= rdout_next;
  end
  assign o_rdata = rdout_reg;
endmodule : fifo_host

//--- hdl/fifo_host_pkg.sv
// Purpose: constants shared by the fifo host controller
// Assumes: 20 MHz system clock, 50 ns period
// Notes: pin timing figures are the fifo's own, in ns
package fifo_host_pkg;
  localparam int CLOCK_NS = 50;
  localparam int WORD_BITS = 9;
  localparam int FIFO_WORDS = 32768;
  // register offsets of the controller's own map
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_WDATA = 4'h2;
  localparam logic [3:0] OFS_RDATA = 4'h3;
  localparam logic [3:0] OFS_WCOUNT = 4'h4;
  localparam logic [3:0] OFS_RCOUNT = 4'h5;
  // control register bit positions (write 1 to start; bits 0-3 start an operation, FIRST and DEPTH only select chaining)
  localparam int CTRL_INIT = 0;
  localparam int CTRL_REPLAY = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_READ = 3;
  localparam int CTRL_FIRST = 4;
  localparam int CTRL_DEPTH = 5;
  // pin timing figures in ns, least widths and setup/recovery
  localparam int PULSE_NS = 35;
  localparam int RECOVER_NS = 10;
  localparam int ACCESS_NS = 35;
  // least times round up, never below one cycle
  localparam int PULSE_CYC = (PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
  localparam logic [3:0] RECOVER_CNT = 4'(RECOVER_CYC);
  localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
  // extra read-strobe cycles that cover the two-stage word synchroniser
  localparam logic [3:0] SYNC_CNT = 4'h2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER
  } phase_type;
  typedef enum logic [1:0] {
    OP_INIT, OP_REPLAY, OP_WRITE, OP_READ
  } op_type;
endpackage : fifo_host_pkg

//--- verif/fifo_host_props.sv
// Purpose: pin-level checks on the fifo host controller
// Assumes: package pulse counts give strobe widths of 2 and 4 cycles
// Notes: flags pass two sync stages, so refusals use settled flags
`timescale 1ns/1ps
module fifo_host_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [15:0] o_rdata,
  input wire logic o_write_n,
  input wire logic o_fetch_n,
  input wire logic o_init_n,
  input wire logic i_empty_flag_n,
  input wire logic i_full_flag_n,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // strobe low spans, then release
  sequence s_wlow;
    (!o_write_n) [*2] ##1 o_write_n;
  endsequence
  sequence s_flow;
    (!o_fetch_n) [*4] ##1 o_fetch_n;
  endsequence
  property p_wwidth; $fell(o_write_n) |-> s_wlow; endproperty
  a_wwidth: assert property (p_wwidth) else $error("write width");
  property p_fwidth; $fell(o_fetch_n) |-> s_flow; endproperty
  a_fwidth: assert property (p_fwidth) else $error("read width");
  property p_initq; !o_init_n |-> o_write_n && o_fetch_n; endproperty
  a_initq: assert property (p_initq) else $error("strobe in init");
  // a full device must never see a new write strobe
  property p_nofull; !i_full_flag_n [*6] |=> !$fell(o_write_n); endproperty
  a_nofull: assert property (p_nofull) else $error("write on full");
  property p_noempt; !i_empty_flag_n [*6] |=> !$fell(o_fetch_n); endproperty
  a_noempt: assert property (p_noempt) else $error("read on empty");
  property p_wbusy; $fell(o_write_n) || $fell(o_fetch_n) |-> o_busy;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("strobe idle");
  property p_start;
    i_write && i_addr == fifo_host_pkg::OFS_CTRL && i_wdata[0] && !o_busy
      |=> o_busy;
  endproperty
  a_start: assert property (p_start) else $error("init not run");
  property p_rdz; !i_read |=> o_rdata == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("stray read data");
endmodule : fifo_host_props
bind fifo_host fifo_host_props u_props (.i_clock, .i_rst_n, .i_addr,
  .i_wdata, .i_write, .i_read, .o_rdata, .o_write_n, .o_fetch_n,
  .o_init_n, .i_empty_flag_n, .i_full_flag_n, .o_busy);

//--- verif/fifo_device_model.sv
// Purpose: behavioural fifo device in single mode
// Assumes: chain input grounded; depth shortened by parameter
// Notes: a released output shows the inverse of the last word
`timescale 1ns/1ps
module fifo_device_model #(
  parameter int DEPTH = 32768
) (
  input wire logic i_init_n,
  input wire logic i_write_n,
  input wire logic i_fetch_n,
  input wire logic i_replay_n,
  input wire logic [8:0] i_in_word,
  output logic [8:0] o_out_word,
  output logic o_empty_flag_n,
  output logic o_full_flag_n,
  output logic o_half_level_flag_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] last = 9'h000;
  logic wok = 1'b0;
  logic rok = 1'b0;
  int wp = 0, rp = 0, cnt = 0;
  // active-low flags follow the fill level
  assign o_empty_flag_n = cnt != 0;
  assign o_full_flag_n = cnt != DEPTH;
  assign o_half_level_flag_n = cnt <= DEPTH / 2;
  // word shown only during an allowed read
  assign o_out_word = (!i_fetch_n && rok) ? last : ~last;
  // cycles start on an allowed falling strobe or, for a strobe held low, on the other strobe's rise
  always @(negedge i_write_n) wok = cnt != DEPTH;
  always @(negedge i_fetch_n)
  begin
    rok = cnt != 0;
    if (rok) last = mem[rp];
  end
  // store on the rising strobe, in order, wrapping
  always @(posedge i_write_n)
    if (wok && i_init_n)
    begin
      mem[wp] = i_in_word;
      wp = (wp + 1) % DEPTH;
      cnt++;
      // read held low on empty: the new word flows through
      if (!i_fetch_n && !rok)
      begin
        rok = 1'b1;
        last = mem[rp];
      end
    end
  always @(posedge i_fetch_n)
    if (rok && i_init_n)
    begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      // write held low on full takes the freed place on rising
      if (!i_write_n && !wok)
        wok = 1'b1;
    end
  // init clears both pointers, replay rewinds reads only
  always @(i_init_n or i_replay_n)
    if (!i_init_n)
    begin
      {wok, rok} = 2'b00;
      {wp, rp, cnt} = 96'h0;
    end
    else if (!i_replay_n)
    begin
      rp = 0;
      cnt = wp;
    end
endmodule : fifo_device_model

//--- verif/fifo_host_test.sv
// Purpose: self-checking bench for the fifo host controller
// Assumes: device model shortened to sixteen words
// Notes: words come from an lfsr and wait in a queue for comparison
`timescale 1ns/1ps
module fifo_host_test;
  localparam int D = 16;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [15:0] o_rdata, s;
  logic [8:0] iw, ow;
  logic wn, fn, inn, rn, fl, en, fu, hn, o_busy;
  logic [31:0] lfsr = 32'h4E5E817E;
  logic [8:0] q[$];
  int n_fail = 0;
  int cmp_count = 0;
  // 20 MHz clock
  always #25 i_clock = ~i_clock;
  fifo_host dut (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .o_in_word(iw), .i_out_word(ow), .o_write_n(wn),
    .o_fetch_n(fn), .o_init_n(inn), .o_replay_n(rn),
    .o_first_in_chain_n(fl), .i_empty_flag_n(en), .i_full_flag_n(fu),
    .i_half_level_flag_n(hn), .o_busy);
  fifo_device_model #(.DEPTH(D)) u_dev (.i_init_n(inn), .i_write_n(wn),
    .i_fetch_n(fn), .i_replay_n(rn), .i_in_word(iw), .o_out_word(ow),
    .o_empty_flag_n(en), .o_full_flag_n(fu), .o_half_level_flag_n(hn));
  // expected active-low flags for a fill level
  function automatic logic [15:0] flags(input int n);
    return {13'h0000, n <= D / 2, n != D, n != 0};
  endfunction : flags
  // next value of the stimulus lfsr
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_step
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    {i_addr, i_wdata, i_write} <= {a, d, 1'b1};
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    {i_addr, i_read} <= {a, 1'b1};
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 s = o_rdata;
  endtask : rd
  // bounded wait for busy to clear, then let synced flags settle
  task automatic cmd(input logic [15:0] c);
    wr(fifo_host_pkg::OFS_CTRL, c);
    #1;
    for (int i = 0; i < 40 && o_busy !== 1'b0; i++) @(posedge i_clock) #1;
    // a command that never finishes counts as a mismatch
    chk({15'h0000, o_busy}, 16'h0000);
    repeat (3) @(posedge i_clock);
  endtask : cmd
  task automatic put();
    lfsr = lfsr_step(lfsr);
    q.push_back(lfsr[8:0]);
    wr(fifo_host_pkg::OFS_WDATA, {7'h00, lfsr[8:0]});
    cmd(16'h0004);
  endtask : put
  task automatic st(input int n);
    rd(fifo_host_pkg::OFS_STATUS);
    chk(s & 16'h0007, flags(n));
  endtask : st
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(4'hF);
    chk(s, 16'h0000);
    cmd(16'h0001);
    st(0);
    cmd(16'h0008);
    rd(fifo_host_pkg::OFS_STATUS);
    chk(s & 16'h0010, 16'h0010);
    for (int i = 1; i <= D; i++)
    begin
      put();
      st(i);
    end
    cmd(16'h0004);
    rd(fifo_host_pkg::OFS_STATUS);
    chk(s & 16'h0010, 16'h0010);
    rd(fifo_host_pkg::OFS_WCOUNT);
    chk(s, 16'(D));
    // replay refused in depth mode while full; half bit forced high
    cmd(16'h0022);
    rd(fifo_host_pkg::OFS_STATUS);
    chk(s & 16'h0017, 16'h0015);
    for (int i = D - 1; i >= 0; i--)
    begin
      cmd(16'h0008);
      rd(fifo_host_pkg::OFS_RDATA);
      chk(s, {7'h00, q.pop_front()});
      st(i);
    end
    cmd(16'h0001);
    repeat (3) put();
    repeat (2) cmd(16'h0008);
    cmd(16'h0002);
    rd(fifo_host_pkg::OFS_RCOUNT);
    chk(s, 16'h0000);
    cmd(16'h0008);
    rd(fifo_host_pkg::OFS_RDATA);
    chk(s, {7'h00, q[0]});
    cmd(16'h0022);
    rd(fifo_host_pkg::OFS_STATUS);
    chk(s & 16'h0014, 16'h0014);
    // depth init: first device has first-load low, others high
    cmd(16'h0031);
    chk({14'h0000, fl, rn}, 16'h0000);
    st(0);
    cmd(16'h0021);
    chk({14'h0000, fl, rn}, 16'h0003);
    give_verdict();
  end
  // watchdog far beyond the several hundred cycles the run needs
  initial
  begin
    #1000000;
    n_fail++;
    give_verdict();
  end
endmodule : fifo_host_test
